//--- shared/otp_seq_pkg.sv
// constants, types and register map for the one-time-programmable memory sequencer
package otp_seq_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int ARRAY_BITS = 40;
   localparam int SLICE_BITS = 10;
   localparam int LOCK_POS   = 39;
   localparam int CFG_BITS   = 39;

   // ****************************************
   // operation codes
   // ****************************************
   localparam logic [1:0] OP_NONE_A  = 2'h0;
   localparam logic [1:0] OP_REFRESH = 2'h1;
   localparam logic [1:0] OP_ZAP     = 2'h2;
   localparam logic [1:0] OP_NONE_B  = 2'h3;

   // ****************************************
   // register word offsets (byte address is four times the offset)
   // ****************************************
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h1;
   localparam logic [3:0] REG_SLICE   = 4'h2;
   localparam logic [3:0] REG_SHADOW0 = 4'h3;
   localparam logic [3:0] REG_SHADOW1 = 4'h4;
   localparam int         ADDR_W      = 6;

   // ctrl fields
   localparam int CTRL_OP_LSB  = 0;
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_BL_POS  = 8;
   localparam int CTRL_BH_POS  = 9;
   // status fields
   localparam int ST_BUSY_POS = 0;
   localparam int ST_FAIL_POS = 1;
   localparam int ST_LOCK_POS = 2;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ        = 25_000_000;
   localparam int REFRESH_NS    = 2_000;
   localparam int ZAP_US        = 1_000;
   localparam int REFRESH_CYC   = (REFRESH_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
   localparam int ZAP_CYC       = ZAP_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W         = 16;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_REFRESH = 2'b01,
      ST_ZAP     = 2'b10
   } seq_state_e;

   // bias controls steering the array sense
   typedef struct packed {
      logic bias_high;
      logic bias_low;
   } bias_s;

endpackage : otp_seq_pkg

//--- logic/otp_operation_sequencer.sv
// one-time-programmable memory sequencer with avalon-mm register slave
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module otp_operation_sequencer #(
   parameter int ZAP_CYCLES = otp_seq_pkg::ZAP_CYC
) (
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   // avalon-mm slave
   input  wire logic [otp_seq_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [31:0]                   avs_readdata,
   output logic                               avs_waitrequest,
   // supply monitor pin
   input  wire logic                          program_supply_undervoltage,
   // array macro: sensed content and burn path
   input  wire logic [otp_seq_pkg::ARRAY_BITS-1:0] array_sense_data,
   output logic      [otp_seq_pkg::ARRAY_BITS-1:0] array_burn_data,
   output logic                               array_burn_en,
   output logic                               array_sense_en,
   output otp_seq_pkg::bias_s                 array_bias
);

   // ****************************************
   // registers and state
   // ****************************************
   otp_seq_pkg::seq_state_e             state;
   logic [otp_seq_pkg::CNT_W-1:0]       cnt;
   logic [otp_seq_pkg::ARRAY_BITS-1:0]  copy;
   logic [otp_seq_pkg::CFG_BITS-1:0]    shadow;
   logic [1:0]                          slice_sel;
   otp_seq_pkg::bias_s                  bias;
   logic [1:0]                          last_op;
   logic                                fail;
   logic                                lock_seen;
   logic                                lock_known;
   logic [otp_seq_pkg::SLICE_BITS-1:0]  slice;
   logic                                uv_meta;
   logic                                uv_sync;
   logic                                pend;
   logic                                busy;

   function automatic logic [otp_seq_pkg::SLICE_BITS-1:0] pick_slice(
      input logic [otp_seq_pkg::ARRAY_BITS-1:0] bits,
      input logic [1:0]                         sel);
      pick_slice = bits[sel*otp_seq_pkg::SLICE_BITS +: otp_seq_pkg::SLICE_BITS];
   endfunction : pick_slice

   // ****************************************
   // bus decode
   // ****************************************
   logic [3:0] word;
   logic       wr_go;
   logic       rd_go;
   logic [1:0] wr_op;

   assign word  = avs_address[otp_seq_pkg::ADDR_W-1:2];
   // one wait cycle per access: read data is captured when the request is first
   // seen so it stands at the edge where waitrequest is sampled low; writes land there
   assign wr_go = avs_write && pend;
   assign rd_go = avs_read && !pend;
   assign wr_op = avs_writedata[otp_seq_pkg::CTRL_OP_LSB +: 2];
   assign busy  = (state != otp_seq_pkg::ST_IDLE);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pend            <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         pend            <= (avs_read || avs_write) && !pend;
         avs_waitrequest <= !((avs_read || avs_write) && !pend);
      end
   end

   // ****************************************
   // undervoltage synchroniser
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         uv_meta <= 1'b0;
         uv_sync <= 1'b0;
      end else begin
         uv_meta <= program_supply_undervoltage;
         uv_sync <= uv_meta;
      end
   end

   // ****************************************
   // control and shadow registers
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slice_sel <= 2'h0;
         bias      <= '0;
         shadow    <= '0;
      end else if (wr_go) begin
         if (word == otp_seq_pkg::REG_CTRL && avs_byteenable[0]) begin
            slice_sel <= avs_writedata[otp_seq_pkg::CTRL_SEL_LSB +: 2];
         end
         if (word == otp_seq_pkg::REG_CTRL && avs_byteenable[1]) begin
            bias.bias_low  <= avs_writedata[otp_seq_pkg::CTRL_BL_POS];
            bias.bias_high <= avs_writedata[otp_seq_pkg::CTRL_BH_POS];
         end
         if (word == otp_seq_pkg::REG_SHADOW0) begin
            for (int b = 0; b < 4; b++) begin
               if (avs_byteenable[b]) begin
                  shadow[b*8 +: 8] <= avs_writedata[b*8 +: 8];
               end
            end
         end
         if (word == otp_seq_pkg::REG_SHADOW1 && avs_byteenable[0]) begin
            shadow[otp_seq_pkg::CFG_BITS-1:32] <= avs_writedata[6:0];
         end
      end
   end

   // ****************************************
   // operation sequencer
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state          <= otp_seq_pkg::ST_IDLE;
         cnt            <= '0;
         last_op        <= otp_seq_pkg::OP_NONE_A;
         array_burn_en  <= 1'b0;
         array_sense_en <= 1'b0;
         array_burn_data <= '0;
      end else begin
         unique case (state)
            otp_seq_pkg::ST_IDLE: begin
               // ignored while busy by construction: only idle accepts an op
               if (wr_go && word == otp_seq_pkg::REG_CTRL && avs_byteenable[0]) begin
                  last_op <= wr_op;
                  if (wr_op == otp_seq_pkg::OP_REFRESH) begin
                     state          <= otp_seq_pkg::ST_REFRESH;
                     array_sense_en <= 1'b1;
                     cnt <= otp_seq_pkg::CNT_W'(otp_seq_pkg::REFRESH_CYC - 1);
                  end else if (wr_op == otp_seq_pkg::OP_ZAP && !lock_seen
                               && lock_known) begin
                     // zap only while the lock is known to be unprogrammed
                     state           <= otp_seq_pkg::ST_ZAP;
                     array_burn_en   <= 1'b1;
                     array_burn_data <= {1'b1, shadow};
                     cnt <= otp_seq_pkg::CNT_W'(ZAP_CYCLES - 1);
                  end
                  // codes 0x0 and 0x3 start no operation; only last_op records them
               end
            end
            otp_seq_pkg::ST_REFRESH: begin
               if (cnt == '0) begin
                  state          <= otp_seq_pkg::ST_IDLE;
                  array_sense_en <= 1'b0;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            otp_seq_pkg::ST_ZAP: begin
               if (cnt == '0) begin
                  state         <= otp_seq_pkg::ST_IDLE;
                  array_burn_en <= 1'b0;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: begin
               state <= otp_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // margin bias drives the sense amplifiers during refresh reads
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         array_bias <= '0;
      end else begin
         array_bias <= bias;
      end
   end

   // ****************************************
   // internal copy and lock tracking
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         copy       <= '0;
         lock_seen  <= 1'b0;
         lock_known <= 1'b0;
      end else begin
         if (state == otp_seq_pkg::ST_REFRESH && cnt == '0) begin
            // whole array captured at end of sense window
            copy      <= array_sense_data;
            // lock state is unknown after reset until a refresh has sensed it
            lock_known <= 1'b1;
            lock_seen <= lock_seen | array_sense_data[otp_seq_pkg::LOCK_POS];
         end
         if (state == otp_seq_pkg::ST_ZAP && cnt == '0) begin
            lock_seen <= 1'b1;
         end
      end
   end

   // read slice follows select after a refresh
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slice <= '0;
      end else begin
         slice <= pick_slice(copy, slice_sel);
      end
   end

   // ****************************************
   // failure flag
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fail <= 1'b0;
      end else if (state == otp_seq_pkg::ST_ZAP && uv_sync) begin
         fail <= 1'b1;
      end else if (rd_go && word == otp_seq_pkg::REG_STATUS) begin
         fail <= 1'b0;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_readdata <= otp_seq_pkg::RESET_WORD;
      end else if (rd_go) begin
         avs_readdata <= otp_seq_pkg::RESET_WORD;
         unique case (word)
            otp_seq_pkg::REG_CTRL: begin
               avs_readdata[otp_seq_pkg::CTRL_OP_LSB +: 2]  <= last_op;
               avs_readdata[otp_seq_pkg::CTRL_SEL_LSB +: 2] <= slice_sel;
               avs_readdata[otp_seq_pkg::CTRL_BL_POS]       <= bias.bias_low;
               avs_readdata[otp_seq_pkg::CTRL_BH_POS]       <= bias.bias_high;
            end
            otp_seq_pkg::REG_STATUS: begin
               avs_readdata[otp_seq_pkg::ST_BUSY_POS] <= busy;
               avs_readdata[otp_seq_pkg::ST_FAIL_POS] <= fail;
               avs_readdata[otp_seq_pkg::ST_LOCK_POS] <= lock_seen;
            end
            otp_seq_pkg::REG_SLICE: begin
               avs_readdata[otp_seq_pkg::SLICE_BITS-1:0] <= slice;
            end
            otp_seq_pkg::REG_SHADOW0: begin
               avs_readdata <= shadow[31:0];
            end
            otp_seq_pkg::REG_SHADOW1: begin
               avs_readdata[6:0] <= shadow[otp_seq_pkg::CFG_BITS-1:32];
            end
            default: begin
               avs_readdata <= otp_seq_pkg::RESET_WORD;
            end
         endcase
      end
   end

endmodule : otp_operation_sequencer

//--- verification/otp_array_model.sv
// behavioural array macro on the far side of the sequencer's burn and sense pins
`timescale 1ns/1ps
module otp_array_model (
   // clock
   input  wire logic        ref_clk,
   // burn and sense path
   input  wire logic        burn_en,
   input  wire logic [39:0] burn_data,
   input  wire logic        sense_en,
   output logic      [39:0] sense_data
);
   logic [39:0] cells = 40'h00_0000_0000;
   // fuses only ever go from 0 to 1
   always @(posedge ref_clk) begin
      if (burn_en) begin
         cells <= cells | burn_data;
      end
   end
   // outside a sense window the lines carry the inverted cell content
   assign sense_data = sense_en ? cells : ~cells;
endmodule : otp_array_model

//--- verification/otp_seq_sva.sv
// assertion checker for the otp operation sequencer
`timescale 1ns/1ps
module otp_seq_sva #(
   parameter int ZAP_CYCLES = 20
) (
   input wire logic                                ref_clk,
   input wire logic                                rst,
   input wire logic [otp_seq_pkg::ARRAY_BITS-1:0] array_burn_data,
   input wire logic                                array_burn_en,
   input wire logic                                array_sense_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [15:0] sense_cnt;
   logic [15:0] burn_cnt;
   logic        burned;
   always_ff @(posedge ref_clk) begin
      sense_cnt <= (rst || !array_sense_en) ? 16'h0000 : sense_cnt + 16'h0001;
   end
   always_ff @(posedge ref_clk) begin
      burn_cnt <= (rst || !array_burn_en) ? 16'h0000 : burn_cnt + 16'h0001;
   end
   always_ff @(posedge ref_clk) begin
      burned <= rst ? 1'b0 : (burned | (burn_cnt != 16'h0000 && !array_burn_en));
   end
   sequence s_sense_start;
      $rose(array_sense_en);
   endsequence
   sequence s_burn_start;
      $rose(array_burn_en);
   endsequence
   a_sense_length: assert property ($fell(array_sense_en) |->
      sense_cnt == 16'(otp_seq_pkg::REFRESH_CYC)) else $error("refresh window length wrong");
   a_burn_length: assert property ($fell(array_burn_en) |->
      burn_cnt == 16'(ZAP_CYCLES)) else $error("burn window length wrong");
   a_lock_burned: assert property (array_burn_en |->
      array_burn_data[otp_seq_pkg::LOCK_POS]) else $error("lock bit not burned");
   a_no_overlap: assert property (!(array_burn_en && array_sense_en))
      else $error("burn and sense at once");
   a_sense_holds: assert property (s_sense_start |-> array_sense_en[*8])
      else $error("refresh cut short");
   a_burn_holds: assert property (s_burn_start |-> array_burn_en[*8])
      else $error("burn cut short");
   a_burn_stable: assert property (array_burn_en && $past(array_burn_en) |->
      $stable(array_burn_data)) else $error("burn data moved");
   a_lock_once: assert property (burned |-> !array_burn_en)
      else $error("second burn");
endmodule : otp_seq_sva
bind otp_operation_sequencer otp_seq_sva #(.ZAP_CYCLES(ZAP_CYCLES)) u_sva (
   .ref_clk(ref_clk), .rst(rst), .array_burn_data(array_burn_data),
   .array_burn_en(array_burn_en), .array_sense_en(array_sense_en));

//--- verification/otp_operation_sequencer_tb_top.sv
// self-checking bench for the otp operation sequencer
`timescale 1ns/1ps
module otp_operation_sequencer_tb_top;
   logic               ref_clk = 1'b0;
   logic               rst = 1'b1;
   logic [5:0]         avs_address = 6'h00;
   logic               avs_read = 1'b0;
   logic               avs_write = 1'b0;
   logic [31:0]        avs_writedata = 32'h0000_0000;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic               uv = 1'b0;
   logic [39:0]        sense_data;
   logic [39:0]        burn_data;
   logic               burn_en;
   logic               sense_en;
   otp_seq_pkg::bias_s bias;
   int                 failures = 0;
   int                 checks_done = 0;
   int                 cyc = 0;
   logic [31:0]        r;
   logic               fail_seen = 1'b0;
   logic [39:0]        exp_arr;
   always #20 ref_clk = ~ref_clk;
   otp_operation_sequencer #(.ZAP_CYCLES(20)) uut (.ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .program_supply_undervoltage(uv),
      .array_sense_data(sense_data), .array_burn_data(burn_data), .array_burn_en(burn_en),
      .array_sense_en(sense_en), .array_bias(bias));
   otp_array_model u_array (.ref_clk(ref_clk), .burn_en(burn_en), .burn_data(burn_data),
      .sense_en(sense_en), .sense_data(sense_data));
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // one avalon access, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask : acc
   function automatic logic [31:0] c(input logic [1:0] op, input logic [1:0] s,
                                     input logic [1:0] b);
      return {22'h00_0000, b, 2'h0, s, 2'h0, op};
   endfunction : c
   // polls busy, remembering any failure flag that the polling clears
   // busy reading back 0 ends this wait, else the bench timeout does
   task automatic wait_idle;
      do begin
         acc(1'b0, 6'h04, 32'h0000_0000);
         fail_seen = fail_seen | r[1];
      end while (r[0] !== 1'b0);
   endtask : wait_idle
   task automatic refresh(input int s, input logic [1:0] b);
      acc(1'b1, 6'h00, c(2'h1, 2'(s), b));
      wait_idle();
      acc(1'b0, 6'h08, 32'h0000_0000);
      chk(r[9:0], exp_arr[s*10 +: 10], "slice");
   endtask : refresh
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      exp_arr = 40'h00_0000_0000;
      acc(1'b1, 6'h14, 32'hFFFF_FFFF);
      acc(1'b0, 6'h14, 32'h0000_0000);
      chk(r, 40'h00_0000_0000, "unmapped");
      acc(1'b0, 6'h04, 32'h0000_0000);
      chk(r[2:0], 40'h00_0000_0000, "status after reset");
      for (int s = 0; s < 4; s++) refresh(s, 2'h3);
      chk(bias, 40'h00_0000_0003, "bias both");
      for (int k = 0; k < 2; k++) begin
         acc(1'b1, 6'h00, c(k ? 2'h3 : 2'h0, 2'h0, 2'h3));
         chk(sense_en | burn_en, 40'h00_0000_0000, "no operation started");
         acc(1'b0, 6'h04, 32'h0000_0000);
         chk(r[0], 40'h00_0000_0000, "busy after no operation");
      end
      $display("test blank and no operation done");
      acc(1'b1, 6'h0C, 32'h1234_5678);
      acc(1'b1, 6'h10, 32'h0000_005A);
      exp_arr = 40'hDA_1234_5678;
      acc(1'b1, 6'h00, c(2'h2, 2'h0, 2'h3));
      acc(1'b0, 6'h04, 32'h0000_0000);
      chk(r[0], 40'h00_0000_0001, "busy in burn");
      chk(burn_data, exp_arr, "burn data");
      uv <= 1'b1;
      repeat (4) @(posedge ref_clk);
      uv <= 1'b0;
      acc(1'b1, 6'h00, c(2'h1, 2'h0, 2'h3));
      fail_seen = 1'b0;
      wait_idle();
      chk({r[2], fail_seen, sense_en}, 40'h00_0000_0006, "lock, fail, no refresh");
      acc(1'b0, 6'h04, 32'h0000_0000);
      chk(r[1], 40'h00_0000_0000, "fail cleared by read");
      $display("test burn done");
      for (int b = 1; b < 3; b++) begin
         for (int s = 0; s < 4; s++) refresh(s, 2'(b));
         chk(bias, 40'(b), "bias margin");
      end
      acc(1'b1, 6'h08, 32'h0000_03FF);
      acc(1'b0, 6'h08, 32'h0000_0000);
      chk(r[9:0], exp_arr[39:30], "slice read only");
      $display("test verify done");
      acc(1'b1, 6'h0C, 32'hFFFF_FFFF);
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            rst <= 1'b1;
            repeat (5) @(posedge ref_clk);
            rst <= 1'b0;
            @(posedge ref_clk);
            acc(1'b1, 6'h0C, 32'hFFFF_FFFF);
            acc(1'b1, 6'h00, c(2'h2, 2'h3, 2'h3));
            chk(burn_en, 40'h00_0000_0000, "burn before lock sensed");
         end
         refresh(3, 2'h3);
         acc(1'b1, 6'h00, c(2'h2, 2'h3, 2'h3));
         chk(burn_en, 40'h00_0000_0000, "burn when locked");
         for (int s = 0; s < 4; s++) refresh(s, 2'h3);
      end
      $display("test locked done");
      end_of_test();
   end
endmodule : otp_operation_sequencer_tb_top
